// ---- src/fifo16x4_pkg.sv ----
// Shared constants and carrier types for the 16x4 strobe-driven FIFO.
// Assumes a single 50 MHz system clock; strobes are sampled on it.
package fifo16x4_pkg;
    localparam int WORD_W = 4;
    localparam int DEPTH = 16;
    localparam int PTR_W = 4;
    localparam int CNT_W = 5;
    localparam int CLK_PERIOD_NS = 20;
    localparam int FALL_THROUGH_NS = 50;
    // Longest time rounds down, never below one cycle
    localparam int FALL_THROUGH_CYC =
        (FALL_THROUGH_NS / CLK_PERIOD_NS) < 1 ? 1 :
        (FALL_THROUGH_NS / CLK_PERIOD_NS);
    localparam logic [PTR_W-1:0] PTR_RESET = 4'h0;
    localparam logic [CNT_W-1:0] CNT_RESET = 5'h00;
    localparam logic [CNT_W-1:0] CNT_FULL = 5'h10;
    localparam logic [WORD_W-1:0] WORD_RESET = 4'h0;

    typedef struct packed {
        logic [WORD_W-1:0] data;
        logic [WORD_W-1:0] data_oe_n;
    } data_pins_t;

    typedef struct packed {
        logic space_available_flag;
        logic word_available_flag;
    } flags_t;
endpackage

// ---- src/strobe_edge.sv ----
// Edge detector for one strobe input sampled on the system clock.
// Assumes the strobe is synchronous to the clock.
`timescale 1ns/1ps
module strobe_edge (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic idle_level_i,
    input wire logic strobe_i,
    output logic rise_o,
    output logic fall_o
);
    logic last_reg;

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            last_reg <= 1'b0;
        end else begin
            last_reg <= strobe_i;
        end
    end

    // Idle level seeds the history so release does not fake an edge
    logic seen_reg;
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            seen_reg <= 1'b0;
        end else begin
            seen_reg <= 1'b1;
        end
    end

    logic prev;
    assign prev = seen_reg ? last_reg : idle_level_i;
    assign rise_o = strobe_i & ~prev;
    assign fall_o = ~strobe_i & prev;
endmodule

// ---- src/strobe_fifo16x4.sv ----
// 16 words by 4 bits FIFO, loaded and unloaded by sampled strobes.
// Assumes strobes and clear are synchronous to SYS_CLK_I and that
// strobe pulses last at least one clock in each level.
`timescale 1ns/1ps

// Overview of operation
// [RL1] Falling load strobe edge stores input word when not full.
// [RL2] Rising unload strobe edge advances to next word when not empty.
// [RL3] Writer idles load strobe low; reader idles unload strobe high.
// [RL4] Full when loads exceed unloads by sixteen.
// [RL5] Loads while full change neither storage nor pointers.
// [RL6] Unloads while empty change neither pointers nor outputs.
// [RL7] Space flag high only when not full and load strobe low.
// [RL8] Word flag high only when not empty and unload strobe high.
// [RL9] Clear resets pointers, raises space flag, drops word flag.
// [RL10] Output word equals loaded word, not inverted.
// [RL11] Data pins float while output enable is low.
// [RL12] Output enable never touches either flag.
// [RL13] Sixteen four-bit words, one whole word per operation.
// [RL14] Side-by-side devices AND their flags externally.
// [RL15] Cascading gives fifteen words per device plus one.
// [RL16] Presented word is invalid while count is zero.
// [RL17] Word into empty buffer falls through and raises word flag.
// [RL18] Clear overrides strobes while low; operations resume after.
module strobe_fifo16x4 (
    input wire logic SYS_CLK_I,
    input wire logic RST_B_I,
    input wire logic LOAD_STROBE_I,
    input wire logic UNLOAD_STROBE_I,
    input wire logic POINTER_CLEAR_N_I,
    input wire logic OUTPUT_ENABLE_I,
    input wire logic [fifo16x4_pkg::WORD_W-1:0] DATA_I,
    output fifo16x4_pkg::data_pins_t DATA_PINS_O,
    output fifo16x4_pkg::flags_t FLAGS_O
);
    import fifo16x4_pkg::*;

    logic [WORD_W-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr_reg;
    logic [PTR_W-1:0] rd_ptr_reg;
    logic [CNT_W-1:0] stored_word_count_reg;
    logic load_fall;
    logic unload_rise;
    logic full;
    logic empty;
    logic do_load;
    logic do_unload;
    logic [WORD_W-1:0] head_next;
    data_pins_t pins_reg;
    flags_t flags_reg;

    strobe_edge u_load_edge (
        .clk_i(SYS_CLK_I),
        .rst_b_i(RST_B_I),
        .idle_level_i(1'b0),
        .strobe_i(LOAD_STROBE_I),
        .rise_o(),
        .fall_o(load_fall)
    );

    strobe_edge u_unload_edge (
        .clk_i(SYS_CLK_I),
        .rst_b_i(RST_B_I),
        .idle_level_i(1'b1),
        .strobe_i(UNLOAD_STROBE_I),
        .rise_o(unload_rise),
        .fall_o()
    );

    // [RL4] full at sixteen
    assign full = (stored_word_count_reg == CNT_FULL);
    assign empty = (stored_word_count_reg == CNT_RESET);
    // [RL1] [RL5] [RL18] load gating
    assign do_load = load_fall & ~full & POINTER_CLEAR_N_I;
    // [RL2] [RL6] [RL18] unload gating
    assign do_unload = unload_rise & ~empty & POINTER_CLEAR_N_I;

    // [RL13] one full word per load
    always_ff @(posedge SYS_CLK_I) begin
        if (do_load) begin
            mem[wr_ptr_reg] <= DATA_I;
        end
    end

    // [RL9] clear resets pointers
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_B_I || !POINTER_CLEAR_N_I) begin
            wr_ptr_reg <= PTR_RESET;
            rd_ptr_reg <= PTR_RESET;
        end else begin
            if (do_load) begin
                wr_ptr_reg <= wr_ptr_reg + 4'h1;
            end
            if (do_unload) begin
                rd_ptr_reg <= rd_ptr_reg + 4'h1;
            end
        end
    end

    // Counter tracks occupancy; simultaneous load and unload cancel
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_B_I || !POINTER_CLEAR_N_I) begin
            stored_word_count_reg <= CNT_RESET;
        end else if (do_load && !do_unload) begin
            stored_word_count_reg <= stored_word_count_reg + 5'h01;
        end else if (do_unload && !do_load) begin
            stored_word_count_reg <= stored_word_count_reg - 5'h01;
        end
    end

    // Head word: fresh input falls through when empty or the head
    // is being unloaded and the next slot is the one being written
    always_comb begin
        head_next = pins_reg.data;
        if (do_unload) begin
            if (stored_word_count_reg == 5'h01) begin
                head_next = do_load ? DATA_I : pins_reg.data;
            end else begin
                head_next = mem[rd_ptr_reg + 4'h1];
            end
        end else if (do_load && empty) begin
            head_next = DATA_I;
        end
    end

    // [RL10] [RL17] [RL6] non-inverted head, held while empty
    // [RL11] enable low floats the data pins
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_B_I) begin
            pins_reg.data <= WORD_RESET;
            pins_reg.data_oe_n <= {WORD_W{1'b1}};
        end else begin
            pins_reg.data <= head_next;
            pins_reg.data_oe_n <= {WORD_W{~OUTPUT_ENABLE_I}};
        end
    end

    // [RL7] [RL8] [RL9] [RL12] [RL16] flags, independent of enable
    always_ff @(posedge SYS_CLK_I) begin
        if (!RST_B_I || !POINTER_CLEAR_N_I) begin
            flags_reg.space_available_flag <= 1'b1;
            flags_reg.word_available_flag <= 1'b0;
        end else begin
            flags_reg.space_available_flag <= ~LOAD_STROBE_I &
                ~((stored_word_count_reg == 5'h0F) & do_load &
                  ~do_unload) & ~(full & ~do_unload);
            flags_reg.word_available_flag <= UNLOAD_STROBE_I &
                ~((stored_word_count_reg == 5'h01) & do_unload &
                  ~do_load) & ~(empty & ~do_load);
        end
    end

    assign DATA_PINS_O = pins_reg;
    assign FLAGS_O = flags_reg;

    // Checks
    a_full_no_store: assert property (@(posedge SYS_CLK_I) // [RL5]
        disable iff (!RST_B_I)
        full && !unload_rise && POINTER_CLEAR_N_I |=>
        $stable(wr_ptr_reg))
        else $error("write pointer moved while full");
    a_empty_no_move: assert property (@(posedge SYS_CLK_I) // [RL6]
        disable iff (!RST_B_I)
        empty && !load_fall && POINTER_CLEAR_N_I |=>
        $stable(rd_ptr_reg) && $stable(pins_reg.data))
        else $error("read side moved while empty");
    a_count_bound: assert property (@(posedge SYS_CLK_I) // [RL4]
        disable iff (!RST_B_I)
        stored_word_count_reg <= CNT_FULL)
        else $error("count beyond sixteen");
    a_load_counts: assert property (@(posedge SYS_CLK_I) // [RL1]
        disable iff (!RST_B_I)
        do_load && !do_unload && POINTER_CLEAR_N_I |=>
        stored_word_count_reg == $past(stored_word_count_reg) + 5'h01)
        else $error("load did not add a word");
    a_unload_counts: assert property (@(posedge SYS_CLK_I) // [RL2]
        disable iff (!RST_B_I)
        do_unload && !do_load |=>
        stored_word_count_reg == $past(stored_word_count_reg) - 5'h01)
        else $error("unload did not remove a word");
    a_clear_flags: assert property (@(posedge SYS_CLK_I) // [RL9]
        disable iff (!RST_B_I)
        !POINTER_CLEAR_N_I |=> flags_reg.space_available_flag &&
        !flags_reg.word_available_flag && empty)
        else $error("clear did not reset flags");
    a_clear_ptrs: assert property (@(posedge SYS_CLK_I) // [RL18]
        disable iff (!RST_B_I)
        !POINTER_CLEAR_N_I |=> wr_ptr_reg == PTR_RESET &&
        rd_ptr_reg == PTR_RESET)
        else $error("pointers moved while clear held");
    // Clear forces the space flag high whatever the load strobe does
    a_space_flag: assert property (@(posedge SYS_CLK_I) // [RL7]
        disable iff (!RST_B_I)
        flags_reg.space_available_flag && $past(RST_B_I) &&
        $past(POINTER_CLEAR_N_I) |-> !full && !$past(LOAD_STROBE_I))
        else $error("space flag high while full or loading");
    a_word_flag: assert property (@(posedge SYS_CLK_I) // [RL8]
        disable iff (!RST_B_I)
        flags_reg.word_available_flag |-> !empty &&
        $past(UNLOAD_STROBE_I))
        else $error("word flag high while empty or unloading");
    a_fall_through: assert property (@(posedge SYS_CLK_I) // [RL17]
        disable iff (!RST_B_I)
        empty && do_load && POINTER_CLEAR_N_I |=>
        pins_reg.data == $past(DATA_I))
        else $error("word did not fall through");
    a_oe_floats: assert property (@(posedge SYS_CLK_I) // [RL11]
        disable iff (!RST_B_I)
        !OUTPUT_ENABLE_I |=> pins_reg.data_oe_n == 4'hF)
        else $error("pins driven with enable low");
    a_oe_drives: assert property (@(posedge SYS_CLK_I) // [RL11]
        disable iff (!RST_B_I)
        RST_B_I && OUTPUT_ENABLE_I |=> pins_reg.data_oe_n == 4'h0)
        else $error("pins floating with enable high");
    a_load_stores: assert property (@(posedge SYS_CLK_I) // [RL13]
        disable iff (!RST_B_I)
        do_load |=> mem[$past(wr_ptr_reg)] == $past(DATA_I))
        else $error("loaded word not stored");

    c_fill: cover property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
        full);
    c_drain: cover property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
        do_unload && stored_word_count_reg == 5'h01);
    c_both: cover property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
        do_load && do_unload);
    c_clear: cover property (@(posedge SYS_CLK_I) disable iff (!RST_B_I)
        !POINTER_CLEAR_N_I && !empty);
    c_full_unload: cover property (@(posedge SYS_CLK_I)
        disable iff (!RST_B_I) full && do_unload);
endmodule

// ---- tb/fifo_user_model.sv ----
// Writer and reader logic that sit on either side of the FIFO.
// Assumes the bench calls its tasks from one process at a time.
`timescale 1ns/1ps
module fifo_user_model (
    input wire logic clk_i,
    output logic load_strobe_o,
    output logic unload_strobe_o,
    output logic [3:0] data_o
);
    // one device wide: the ANDed first-rank flags are its own
    // one rank deep: no cascade gating is built around it
    initial begin
        load_strobe_o = 1'b0;
        unload_strobe_o = 1'b1;
        data_o = 4'h0;
    end

    task automatic raise_load(input logic [3:0] w);
        @(posedge clk_i) load_strobe_o <= 1'b1;
        data_o <= w;
    endtask

    // Data turns over once the hold after the falling edge has passed
    task automatic drop_load();
        @(posedge clk_i) load_strobe_o <= 1'b0;
        @(posedge clk_i) data_o <= ~data_o;
        @(posedge clk_i);
    endtask

    task automatic load_word(input logic [3:0] w);
        raise_load(w);
        repeat (2) @(posedge clk_i);
        drop_load();
    endtask

    // Load strobe falls as unload strobe rises on one edge, so load and unload coincide
    task automatic swap_word(input logic [3:0] w);
        @(posedge clk_i) load_strobe_o <= 1'b1;
        data_o <= w;
        unload_strobe_o <= 1'b0;
        repeat (2) @(posedge clk_i);
        @(posedge clk_i) load_strobe_o <= 1'b0;
        unload_strobe_o <= 1'b1;
        @(posedge clk_i) data_o <= ~data_o;
        @(posedge clk_i);
    endtask

    task automatic drop_unload();
        @(posedge clk_i) unload_strobe_o <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask

    task automatic raise_unload();
        @(posedge clk_i) unload_strobe_o <= 1'b1;
        repeat (2) @(posedge clk_i);
    endtask
endmodule

// ---- tb/tb.sv ----
// Self-checking bench for the strobe-driven 16x4 FIFO.
// Assumes the user model drives strobes and data; bench owns the rest.
`timescale 1ns/1ps
module tb;
    import fifo16x4_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic clr_n = 1'b1;
    logic oe = 1'b0;
    logic ld, ul;
    logic [3:0] din;
    data_pins_t pins;
    flags_t flg;
    int n_mismatch = 0;
    int n_compared = 0;

    always #10 clk = ~clk;

    fifo_user_model u_user (.clk_i(clk), .load_strobe_o(ld),
        .unload_strobe_o(ul), .data_o(din));

    strobe_fifo16x4 DUT (.SYS_CLK_I(clk), .RST_B_I(rst_b),
        .LOAD_STROBE_I(ld), .UNLOAD_STROBE_I(ul),
        .POINTER_CLEAR_N_I(clr_n), .OUTPUT_ENABLE_I(oe),
        .DATA_I(din), .DATA_PINS_O(pins), .FLAGS_O(flg));

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic end_sim();
        $display("compared=%0d mismatched=%0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic test_reset();
        chk({flg, pins.data_oe_n}, {2'b10, 4'hF});
        $display("test_reset done");
    endtask

    task automatic test_fill_drain();
        u_user.raise_load(4'h9);
        cyc(2);
        chk(flg.space_available_flag, 1'b0);
        u_user.drop_load();
        chk({flg, pins.data}, {2'b11, 4'h9});
        for (int i = 1; i < 16; i++) u_user.load_word(4'(i) ^ 4'h9);
        chk(flg, 2'b01);
        u_user.load_word(4'h6);
        chk(flg, 2'b01);
        for (int i = 0; i < 16; i++) begin
            chk(pins.data, 4'(i) ^ 4'h9);
            u_user.drop_unload();
            if (i == 0) chk(flg.word_available_flag, 1'b0);
            u_user.raise_unload();
        end
        chk(flg, 2'b10);
        u_user.drop_unload();
        u_user.raise_unload();
        // Last word loaded was 4'hF ^ 4'h9; an empty unload must keep it
        chk({flg, pins.data}, {2'b10, 4'h6});
        $display("test_fill_drain done");
    endtask

    task automatic test_clear();
        for (int i = 1; i < 4; i++) u_user.load_word(4'(i));
        chk(flg, 2'b11);
        @(posedge clk) clr_n <= 1'b0;
        u_user.load_word(4'hE);
        chk(flg, 2'b10);
        @(posedge clk) clr_n <= 1'b1;
        cyc(2);
        chk(flg, 2'b10);
        u_user.load_word(4'h7);
        chk({flg, pins.data}, {2'b11, 4'h7});
        $display("test_clear done");
    endtask

    task automatic test_output_enable();
        @(posedge clk) oe <= 1'b1;
        cyc(2);
        chk({flg, pins.data_oe_n}, {2'b11, 4'h0});
        chk(pins.data, 4'h7);
        @(posedge clk) oe <= 1'b0;
        cyc(2);
        chk({flg, pins.data_oe_n}, {2'b11, 4'hF});
        $display("test_output_enable done");
    endtask

    // Load and unload on one edge, at two words and at one word held
    task automatic test_both();
        u_user.load_word(4'hA);
        u_user.swap_word(4'h5);
        chk({flg, pins.data}, {2'b11, 4'hA});
        u_user.swap_word(4'hC);
        chk({flg, pins.data}, {2'b11, 4'h5});
        u_user.drop_unload();
        u_user.raise_unload();
        chk({flg, pins.data}, {2'b11, 4'hC});
        u_user.swap_word(4'h3);
        chk({flg, pins.data}, {2'b11, 4'h3});
        $display("test_both done");
    endtask

    initial begin
        cyc(3);
        @(posedge clk) rst_b <= 1'b1;
        cyc(2);
        test_reset();
        test_fill_drain();
        test_clear();
        test_output_enable();
        test_both();
        end_sim();
    end

    // Tests take well under 1500 cycles; this cuts a hang short
    initial begin
        #100000;
        n_mismatch++;
        end_sim();
    end
endmodule
